// [rtl/sbsp_pkg.sv]
// sbsp_pkg: shared constants and types for the synchronous burst sram port.
// assumes both ends and the interface refer to it as sbsp_pkg::name.
package sbsp_pkg;
    // array shape, wide variant: 2^18 words of 4 lanes, 9 bits per lane
    localparam int ADDR_W_DEF = 18;
    localparam int LANES_DEF  = 4;
    localparam int LANE_W_DEF = 9;
    // parity bit sits at the top of each lane
    localparam int PARITY_BIT = 8;

    // 2-bit burst counter
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;

    // burst order select level
    localparam logic ORDER_LINEAR = 1'b0;
    localparam logic ORDER_INTLV  = 1'b1;

    // active levels of the strobes
    localparam logic ASSERT_N = 1'b0;
    localparam logic NEGATE_N = 1'b1;

    // read buffer in the master
    localparam int RD_BUF_DEPTH = 2;

    // master sequencer, gray coded
    typedef enum logic [0:0] {
        SBSP_IDLE = 1'b0,
        SBSP_RUN  = 1'b1
    } sbsp_host_state_t;
endpackage

// [rtl/sbsp_if.sv]
// sbsp_if: pins between the burst sram and its bus master.
// assumes both ends run on the same core_clk; the shared data bus is resolved here.
`timescale 1ns/1ps
`default_nettype none
interface sbsp_if #(
    parameter int ADDR_W = sbsp_pkg::ADDR_W_DEF,
    parameter int LANES  = sbsp_pkg::LANES_DEF,
    parameter int LANE_W = sbsp_pkg::LANE_W_DEF
);
    localparam int DW = LANES * LANE_W;

    logic [ADDR_W-1:sbsp_pkg::BURST_W] addr_hi;
    logic [sbsp_pkg::BURST_W-1:0]      burst_low_addr;
    logic                              proc_addr_strobe_n;
    logic                              ctrl_addr_strobe_n;
    logic                              burst_advance_n;
    logic                              global_write_n;
    logic                              byte_write_en_n;
    logic [LANES-1:0]                  lane_write_sel_n;
    logic                              chip_sel_n;
    logic                              chip_sel2_n;
    logic                              chip_sel_hi;
    logic                              out_en_n;
    logic                              sleep_req;
    logic                              burst_order;
    logic [DW-1:0]                     data_lane_dev_out;
    logic                              data_lane_dev_oe;
    logic [DW-1:0]                     data_lane_host_out;
    logic                              data_lane_host_oe;
    logic [DW-1:0]                     data_lane_io;
    logic                              data_lane_float;

    // a floating bus reads as zero; data_lane_float tells it apart
    assign data_lane_io    = data_lane_dev_oe  ? data_lane_dev_out  :
                             data_lane_host_oe ? data_lane_host_out : '0;
    assign data_lane_float = !data_lane_dev_oe && !data_lane_host_oe;

    modport dev (
        input  addr_hi, burst_low_addr, proc_addr_strobe_n, ctrl_addr_strobe_n,
        input  burst_advance_n, global_write_n, byte_write_en_n, lane_write_sel_n,
        input  chip_sel_n, chip_sel2_n, chip_sel_hi, out_en_n, sleep_req, burst_order,
        input  data_lane_io,
        output data_lane_dev_out, data_lane_dev_oe
    );
    modport host (
        output addr_hi, burst_low_addr, proc_addr_strobe_n, ctrl_addr_strobe_n,
        output burst_advance_n, global_write_n, byte_write_en_n, lane_write_sel_n,
        output chip_sel_n, chip_sel2_n, chip_sel_hi, out_en_n, sleep_req, burst_order,
        output data_lane_host_out, data_lane_host_oe,
        input  data_lane_io
    );
endinterface
`default_nettype wire

// [rtl/sbsp_dev.sv]
// sbsp_dev: the flow-through burst sram itself, array, burst counter and pin decode.
// assumes a master on sbsp_if sharing core_clk; out_en_n and sleep_req act without the clock.
//
// Summary of operation
// - all synchronous pins captured on rising edge
// - array write self-timed from clock edge
// - one write updates one to four lanes
// - byte enable plus lane selects writes those lanes
// - global write writes every lane
// - either address strobe starts burst, loads address
// - burst address steps only when advance asserted
// - order select low gives linear bursts
// - order select high gives interleaved bursts
// - two-bit burst counter, four words then wrap
// - low address bits start the burst, counter from zero
// - array of 262144 by 36 or 524288 by 18
// - selected only when all three chip enables active
// - one shared bus, device drives only reads
// - deselect powers down and floats outputs
// - sleep input forces snooze, inputs ignored
// - processor strobe always reads; write next edge
// - write when global or byte enable with lane
// - master suspends burst to insert wait states
// - output enable and sleep are asynchronous
`timescale 1ns/1ps
`default_nettype none
module sbsp_dev #(
    parameter int ADDR_W = sbsp_pkg::ADDR_W_DEF,
    parameter int LANES  = sbsp_pkg::LANES_DEF,
    parameter int LANE_W = sbsp_pkg::LANE_W_DEF
) (
    input  wire logic core_clk,
    input  wire logic rst,
    sbsp_if.dev       pins,
    output logic      pwr_down,
    output logic      snooze
);
    localparam int BW    = sbsp_pkg::BURST_W;
    localparam int DW    = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // next burst low address for a given start, count and order
    function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] start,
                                                input logic [BW-1:0] cnt,
                                                input logic          order);
        logic [BW-1:0] sum;
        sum = start + cnt;
        if (order == sbsp_pkg::ORDER_LINEAR) begin
            return sum;
        end
        return start ^ cnt;
    endfunction

    // lane write mask from the write controls
    function automatic logic [LANES-1:0] lane_mask(input logic             gw_n,
                                                   input logic             bwe_n,
                                                   input logic [LANES-1:0] sel_n);
        logic [LANES-1:0] m;
        m = '0;
        if (gw_n == sbsp_pkg::ASSERT_N) begin
            m = '1;
        end else if (bwe_n == sbsp_pkg::ASSERT_N) begin
            m = ~sel_n;
        end
        return m;
    endfunction

    logic [ADDR_W-1:BW] addr_hi_reg;
    logic [BW-1:0]      start_low_reg;
    logic [BW-1:0]      count_reg;
    logic [BW-1:0]      count_next;
    logic               active_reg;
    logic               active_next;
    logic               read_reg;

    wire logic selected     = (pins.chip_sel_n == sbsp_pkg::ASSERT_N) &&
                              (pins.chip_sel2_n == sbsp_pkg::ASSERT_N) &&
                              pins.chip_sel_hi;
    // processor strobe counts only while the low-active enable is low
    wire logic proc_start   = (pins.proc_addr_strobe_n == sbsp_pkg::ASSERT_N) &&
                              (pins.chip_sel_n == sbsp_pkg::ASSERT_N);
    wire logic any_start    = proc_start ||
                              (pins.ctrl_addr_strobe_n == sbsp_pkg::ASSERT_N);
    wire logic begin_burst  = any_start && selected;
    wire logic deselect     = any_start && !selected;
    wire logic advance      = !any_start && active_reg &&
                              (pins.burst_advance_n == sbsp_pkg::ASSERT_N);
    wire logic asleep       = pins.sleep_req;
    // suspended cycles reuse the current address, which is how wait states work
    wire logic [BW-1:0] cyc_low = begin_burst ? pins.burst_low_addr :
                                  burst_low(start_low_reg, count_next, pins.burst_order);
    wire logic [ADDR_W-1:0] cyc_addr = begin_burst ? {pins.addr_hi, pins.burst_low_addr} :
                                                     {addr_hi_reg, cyc_low};
    // a processor strobe cycle is always a read, whatever the write pins say
    wire logic [LANES-1:0] wr_mask = proc_start ? '0 :
                                     lane_mask(pins.global_write_n, pins.byte_write_en_n,
                                               pins.lane_write_sel_n);
    wire logic live     = !asleep && (begin_burst || (!any_start && active_reg));
    wire logic do_write = live && (|wr_mask);
    wire logic do_read  = live && !(|wr_mask);

    // wrap of the 2-bit counter is plain overflow
    assign count_next  = begin_burst ? sbsp_pkg::BURST_ZERO :
                         advance     ? count_reg + sbsp_pkg::BURST_ONE : count_reg;
    assign active_next = begin_burst ? 1'b1 : deselect ? 1'b0 : active_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_reg <= 1'b0;
            read_reg   <= 1'b0;
        end else begin
            active_reg <= asleep ? active_reg : active_next;
            read_reg   <= do_read;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_hi_reg   <= '0;
            start_low_reg <= sbsp_pkg::BURST_ZERO;
            count_reg     <= sbsp_pkg::BURST_ZERO;
        end else if (!asleep) begin
            count_reg <= count_next;
            if (begin_burst) begin
                addr_hi_reg   <= pins.addr_hi;
                start_low_reg <= pins.burst_low_addr;
            end
        end
    end

    // one array per lane, so each lane write has a single process
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] mem [DEPTH];
            logic [LANE_W-1:0] dout_reg;
            wire logic [LANE_W-1:0] din = pins.data_lane_io[g*LANE_W +: LANE_W];

            // written straight at the edge, no pulse needed from the master
            always_ff @(posedge core_clk) begin
                if (do_write && wr_mask[g]) begin
                    mem[cyc_addr] <= din;
                end
            end

            // flow-through: word fetched at the address edge shows that cycle
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    dout_reg <= '0;
                end else if (do_read) begin
                    dout_reg <= mem[cyc_addr];
                end
            end

            assign pins.data_lane_dev_out[g*LANE_W +: LANE_W] = dout_reg;
        end
    endgenerate

    // output enable and sleep gate the drivers directly, no edge involved
    assign pins.data_lane_dev_oe = read_reg &&
                                   (pins.out_en_n == sbsp_pkg::ASSERT_N) &&
                                   !asleep;
    assign pwr_down = !active_reg;
    assign snooze   = asleep;

endmodule // sbsp_dev
`default_nettype wire

// [rtl/sbsp_host.sv]
// sbsp_host: bus master that runs bursts of one to four words against sbsp_dev.
// assumes sbsp_dev on the far side of sbsp_if and the same core_clk.
`timescale 1ns/1ps
`default_nettype none
module sbsp_host #(
    parameter int ADDR_W = sbsp_pkg::ADDR_W_DEF,
    parameter int LANES  = sbsp_pkg::LANES_DEF,
    parameter int LANE_W = sbsp_pkg::LANE_W_DEF,
    parameter int DEPTH  = sbsp_pkg::RD_BUF_DEPTH
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    sbsp_if.host                               pins,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          req_write,
    input  wire logic [ADDR_W-1:0]             req_addr,
    input  wire logic [sbsp_pkg::BURST_W-1:0]  req_beats,
    input  wire logic [LANES-1:0]              req_lanes,
    input  wire logic                          order_intlv,
    input  wire logic                          sleep_in,
    input  wire logic                          wr_valid,
    output logic                               wr_ready,
    input  wire logic [LANES*LANE_W-1:0]       wr_data,
    output logic                               rd_valid,
    input  wire logic                          rd_ready,
    output logic [LANES*LANE_W-1:0]            rd_data
);
    localparam int BW = sbsp_pkg::BURST_W;
    localparam int DW = LANES * LANE_W;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    sbsp_pkg::sbsp_host_state_t state_reg;
    sbsp_pkg::sbsp_host_state_t state_next;
    logic [BW-1:0]    left_reg;
    logic             wr_lat_reg;
    logic [LANES-1:0] lanes_reg;
    logic             cap_reg;
    logic [DW-1:0]    buf_mem [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    cnt_reg;

    wire logic is_idle    = (state_reg == sbsp_pkg::SBSP_IDLE);
    // a beat in flight already owns one buffer slot
    wire logic room       = ({1'b0, cnt_reg} + {{CW{1'b0}}, cap_reg}) < (CW+1)'(DEPTH);
    // waiting out a capture keeps our write drivers off the device's read data
    wire logic take       = is_idle && req_valid && !cap_reg && !sleep_in &&
                            (req_write ? wr_valid : room);
    wire logic beat_go    = !is_idle && (wr_lat_reg ? wr_valid : room);
    wire logic wr_cyc     = (take && req_write) || (beat_go && wr_lat_reg);
    wire logic rd_issue   = (take && !req_write) || (beat_go && !wr_lat_reg);
    wire logic [LANES-1:0] lanes_sel = take ? req_lanes : lanes_reg;
    wire logic all_lanes  = &lanes_sel;
    // an empty lane mask writes nothing, so the bus is left floating that beat
    wire logic any_lane   = |lanes_sel;
    wire logic push       = cap_reg;
    wire logic pop        = rd_valid && rd_ready;

    assign req_ready = take;
    assign wr_ready  = wr_cyc;
    assign state_next = take ? ((req_beats == sbsp_pkg::BURST_ZERO) ? sbsp_pkg::SBSP_IDLE
                                                                     : sbsp_pkg::SBSP_RUN) :
                        (beat_go && left_reg == sbsp_pkg::BURST_ONE) ? sbsp_pkg::SBSP_IDLE :
                        state_reg;

    // reads start on the processor strobe, writes on the controller strobe;
    // an idle cycle is a controller strobe with chip enable high, which deselects
    assign pins.addr_hi            = req_addr[ADDR_W-1:BW];
    assign pins.burst_low_addr     = req_addr[BW-1:0];
    assign pins.proc_addr_strobe_n = (take && !req_write) ? sbsp_pkg::ASSERT_N
                                                          : sbsp_pkg::NEGATE_N;
    assign pins.ctrl_addr_strobe_n = ((is_idle && !take) || (take && req_write)) ?
                                     sbsp_pkg::ASSERT_N : sbsp_pkg::NEGATE_N;
    assign pins.chip_sel_n         = (take || !is_idle) ? sbsp_pkg::ASSERT_N
                                                        : sbsp_pkg::NEGATE_N;
    assign pins.chip_sel2_n        = sbsp_pkg::ASSERT_N;
    assign pins.chip_sel_hi        = 1'b1;
    // a stalled beat holds advance and both strobes off, so the device waits
    assign pins.burst_advance_n    = beat_go ? sbsp_pkg::ASSERT_N : sbsp_pkg::NEGATE_N;
    assign pins.global_write_n     = (wr_cyc && all_lanes) ? sbsp_pkg::ASSERT_N
                                                           : sbsp_pkg::NEGATE_N;
    assign pins.byte_write_en_n    = (wr_cyc && !all_lanes && any_lane) ? sbsp_pkg::ASSERT_N
                                                                        : sbsp_pkg::NEGATE_N;
    assign pins.lane_write_sel_n   = (wr_cyc && !all_lanes) ? ~lanes_sel : '1;
    assign pins.out_en_n           = cap_reg ? sbsp_pkg::ASSERT_N : sbsp_pkg::NEGATE_N;
    assign pins.sleep_req          = sleep_in && is_idle && !cap_reg;
    assign pins.burst_order        = order_intlv ? sbsp_pkg::ORDER_INTLV
                                                 : sbsp_pkg::ORDER_LINEAR;
    assign pins.data_lane_host_out = wr_data;
    assign pins.data_lane_host_oe  = wr_cyc && any_lane;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg  <= sbsp_pkg::SBSP_IDLE;
            left_reg   <= sbsp_pkg::BURST_ZERO;
            wr_lat_reg <= 1'b0;
            lanes_reg  <= '0;
            cap_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cap_reg   <= rd_issue;
            if (take) begin
                left_reg   <= req_beats;
                wr_lat_reg <= req_write;
                lanes_reg  <= req_lanes;
            end else if (beat_go) begin
                left_reg <= left_reg - sbsp_pkg::BURST_ONE;
            end
        end
    end

    // read buffer: push is only issued when a slot is reserved, so it never overflows
    always_ff @(posedge core_clk) begin
        if (push) begin
            buf_mem[wr_ptr_reg] <= pins.data_lane_io;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
            end
            cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
        end
    end

    assign rd_valid = (cnt_reg != '0);
    assign rd_data  = buf_mem[rd_ptr_reg];

endmodule // sbsp_host
`default_nettype wire

// [bench/sbsp_assertions.sv]
// sbsp_assertions: pin protocol checker for the burst sram port.
// assumes an instance beside sbsp_if, fed its signals by name, one core_clk domain.
`timescale 1ns/1ps
`default_nettype none
module sbsp_assertions #(
    parameter int LANES  = sbsp_pkg::LANES_DEF,
    parameter int LANE_W = sbsp_pkg::LANE_W_DEF
) (
    input wire logic                      core_clk,
    input wire logic                      rst,
    input wire logic                      proc_addr_strobe_n,
    input wire logic                      ctrl_addr_strobe_n,
    input wire logic                      burst_advance_n,
    input wire logic                      global_write_n,
    input wire logic                      byte_write_en_n,
    input wire logic [LANES-1:0]          lane_write_sel_n,
    input wire logic                      chip_sel_n,
    input wire logic                      chip_sel2_n,
    input wire logic                      chip_sel_hi,
    input wire logic                      out_en_n,
    input wire logic                      sleep_req,
    input wire logic [LANES*LANE_W-1:0]   data_lane_dev_out,
    input wire logic                      data_lane_dev_oe,
    input wire logic                      data_lane_host_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    wire logic start_w  = (!proc_addr_strobe_n && !chip_sel_n) || !ctrl_addr_strobe_n;
    wire logic sel_w    = !chip_sel_n && !chip_sel2_n && chip_sel_hi;
    wire logic wr_ctl_w = !global_write_n || (!byte_write_en_n && !(&lane_write_sel_n));
    logic active_reg;
    logic prev_rd_reg;
    // proc strobe begin is a read whatever the write pins say
    wire logic rd_cyc_w = !sleep_req && ((start_w && sel_w && (!proc_addr_strobe_n || !wr_ctl_w)) ||
                                         (!start_w && active_reg && !wr_ctl_w));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_reg  <= 1'b0;
            prev_rd_reg <= 1'b0;
        end else begin
            prev_rd_reg <= rd_cyc_w;
            if (!sleep_req && start_w) begin
                active_reg <= sel_w;
            end
        end
    end

    property p_read_drive;
        rd_cyc_w ##1 (!out_en_n && !sleep_req) |-> data_lane_dev_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");
    property p_deselect;
        !sleep_req && start_w && !sel_w |=> !data_lane_dev_oe;
    endproperty
    a_deselect: assert property (p_deselect) else $error("bus driven after deselect");
    property p_no_clash;
        !(data_lane_dev_oe && data_lane_host_oe);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive the bus");
    property p_write_turn;
        data_lane_host_oe |=> !data_lane_dev_oe;
    endproperty
    a_write_turn: assert property (p_write_turn) else $error("device drives after write");
    property p_sleep_float;
        sleep_req |-> !data_lane_dev_oe;
    endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("bus driven in snooze");
    property p_oe_gate;
        out_en_n |-> !data_lane_dev_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("bus driven with output enable high");
    property p_suspend;
        rd_cyc_w && !start_w && burst_advance_n && prev_rd_reg |=> $stable(data_lane_dev_out);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend changed read data");
    property p_host_write;
        data_lane_host_oe |-> wr_ctl_w && proc_addr_strobe_n;
    endproperty
    a_host_write: assert property (p_host_write) else $error("write data without write cycle");
    property p_sleep_idle;
        sleep_req |-> proc_addr_strobe_n && !data_lane_host_oe;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("master busy in snooze");
endmodule // sbsp_assertions
`default_nettype wire

// [bench/test_sync_burst_sram_port.sv]
// test_sync_burst_sram_port: master and device joined by sbsp_if, driven from the user side.
// assumes rtl/ compiled first; a reference array in the bench predicts every read word.
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_port;
    localparam int AW = 6;
    localparam int LN = sbsp_pkg::LANES_DEF;
    localparam int LW = sbsp_pkg::LANE_W_DEF;
    localparam int DW = LN * LW;
    logic            core_clk    = 1'b0;
    logic            rst         = 1'b1;
    logic            req_valid   = 1'b0;
    logic            req_write   = 1'b0;
    logic [AW-1:0]   req_addr    = '0;
    logic [1:0]      req_beats   = 2'h0;
    logic [LN-1:0]   req_lanes   = 4'hF;
    logic            order_intlv = 1'b0;
    logic            sleep_in    = 1'b0;
    logic            wr_valid    = 1'b0;
    logic [DW-1:0]   wr_data     = '0;
    logic            rd_ready    = 1'b1;
    logic [DW-1:0]   salt        = '0;
    logic            req_ready, wr_ready, rd_valid, pwr_down, snooze;
    logic [DW-1:0]   rd_data;
    logic [DW-1:0]   mem_model [0:(1<<AW)-1];
    int              errors      = 0;
    int              checks_done = 0;

    always #5 core_clk = ~core_clk;

    sbsp_if #(.ADDR_W(AW)) u_sbsp_if ();
    sbsp_dev #(.ADDR_W(AW)) u_sbsp_dev (.core_clk(core_clk), .rst(rst), .pins(u_sbsp_if),
        .pwr_down(pwr_down), .snooze(snooze));
    sbsp_host #(.ADDR_W(AW)) u_sbsp_host (.core_clk(core_clk), .rst(rst), .pins(u_sbsp_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_beats(req_beats), .req_lanes(req_lanes), .order_intlv(order_intlv), .sleep_in(sleep_in),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data));
    sbsp_assertions u_sbsp_assertions (.core_clk(core_clk), .rst(rst),
        .proc_addr_strobe_n(u_sbsp_if.proc_addr_strobe_n), .ctrl_addr_strobe_n(u_sbsp_if.ctrl_addr_strobe_n),
        .burst_advance_n(u_sbsp_if.burst_advance_n), .global_write_n(u_sbsp_if.global_write_n),
        .byte_write_en_n(u_sbsp_if.byte_write_en_n), .lane_write_sel_n(u_sbsp_if.lane_write_sel_n),
        .chip_sel_n(u_sbsp_if.chip_sel_n), .chip_sel2_n(u_sbsp_if.chip_sel2_n),
        .chip_sel_hi(u_sbsp_if.chip_sel_hi), .out_en_n(u_sbsp_if.out_en_n), .sleep_req(u_sbsp_if.sleep_req),
        .data_lane_dev_out(u_sbsp_if.data_lane_dev_out), .data_lane_dev_oe(u_sbsp_if.data_lane_dev_oe),
        .data_lane_host_oe(u_sbsp_if.data_lane_host_oe));

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t ns: %s", $time, msg);
        end
    endtask

    // expected beat address: linear adds the count, interleaved xors it, both wrap in four
    function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] a, input int i, input logic il);
        logic [1:0] c;
        c = 2'(i);
        return {a[AW-1:2], il ? (a[1:0] ^ c) : (a[1:0] + c)};
    endfunction

    function automatic logic [DW-1:0] pat(input logic [AW-1:0] a, input int i);
        return {LN{a, 3'(i)}} ^ salt;
    endfunction

    task automatic do_write(input logic [AW-1:0] a, input logic [1:0] nb, input logic [LN-1:0] ln,
                            input logic il);
        int i = 0;
        int n = 0;
        req_write = 1'b1;
        req_addr = a;
        req_beats = nb;
        req_lanes = ln;
        order_intlv = il;
        req_valid = 1'b1;
        wr_valid = 1'b1;
        wr_data = pat(a, 0);
        while (i <= int'(nb) && n < 50) begin
            // let the combinational ready settle after this step's drives
            #1;
            if ((req_valid ? req_ready : wr_ready) === 1'b1) begin
                @(posedge core_clk);
                for (int j = 0; j < LN; j++) begin
                    if (ln[j]) mem_model[beat_addr(a, i, il)][j*LW +: LW] = wr_data[j*LW +: LW];
                end
                i++;
                @(negedge core_clk);
                req_valid = 1'b0;
                wr_valid = (i <= int'(nb));
                wr_data = pat(a, i);
            end else begin
                @(negedge core_clk);
                n++;
            end
        end
        chk(n < 50, "write burst stalled");
        @(negedge core_clk);
    endtask

    task automatic do_read(input logic [AW-1:0] a, input logic [1:0] nb, input logic il, input int hold);
        int i = 0;
        int n = 0;
        req_write = 1'b0;
        req_addr = a;
        req_beats = nb;
        order_intlv = il;
        req_valid = 1'b1;
        rd_ready = (hold == 0);
        #1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (i <= int'(nb) && n < 80) begin
            rd_ready = (n >= hold);
            if (rd_valid === 1'b1 && rd_ready) begin
                chk(rd_data === mem_model[beat_addr(a, i, il)], "read word differs");
                i++;
            end
            @(negedge core_clk);
            n++;
        end
        chk(i > int'(nb), "read burst incomplete");
        rd_ready = 1'b1;
        @(negedge core_clk);
    endtask

    task automatic t_bursts();
        do_write(6'h06, 2'h3, 4'hF, 1'b0);
        do_read(6'h06, 2'h3, 1'b0, 0);
        do_write(6'h0D, 2'h3, 4'hF, 1'b1);
        do_read(6'h0C, 2'h3, 1'b0, 0);
        do_read(6'h0E, 2'h3, 1'b1, 0);
        do_read(6'h07, 2'h3, 1'b0, 6);
        $display("test bursts done");
    endtask

    task automatic t_byte_lanes();
        logic [LN-1:0] tbl [4] = '{4'hF, 4'h1, 4'h5, 4'h0};
        for (int j = 0; j < 4; j++) begin
            salt = {LN{9'h04B * 9'(j + 1)}};
            do_write(6'h21, 2'h0, tbl[j], 1'b0);
            do_read(6'h21, 2'h0, 1'b0, 0);
        end
        $display("test byte lanes done");
    endtask

    task automatic t_snooze();
        sleep_in = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(snooze === 1'b1, "snooze output low");
        chk(u_sbsp_if.data_lane_float === 1'b1, "bus driven in snooze");
        req_write = 1'b0;
        req_valid = 1'b1;
        @(negedge core_clk);
        chk(req_ready === 1'b0, "request taken in snooze");
        req_valid = 1'b0;
        sleep_in = 1'b0;
        @(negedge core_clk);
        do_read(6'h06, 2'h3, 1'b0, 0);
        $display("test snooze done");
    endtask

    initial begin
        repeat (4000) @(posedge core_clk);
        errors++;
        $display("mismatch at %0t ns: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        chk(pwr_down === 1'b1, "not powered down after reset");
        chk(u_sbsp_if.data_lane_dev_oe === 1'b0, "bus driven after reset");
        t_bursts();
        t_byte_lanes();
        t_snooze();
        close_out();
    end
endmodule // test_sync_burst_sram_port
`default_nettype wire
